/* File: rtl/asr_cfg.svh */
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH
// link geometry
`define ASR_ADDR_W 17
`define ASR_DATA_W 16
// clock period in picoseconds
`define ASR_CLK_PS 4000
// timing figures of the slowest grade, in picoseconds
`define ASR_T_DATA_SETUP_PS 9000
`define ASR_T_ADDR_SETUP_PS 12000
`define ASR_T_LANE_VALID_PS 12000
`define ASR_T_STROBE_DRIVE_ON_PS 17000
`define ASR_T_OE_FLOAT_PS 4000
`define ASR_T_READ_ACCESS_PS 20000
`define ASR_T_STROBE_HIGH_DRIVE_PS 3000
// least times round up to whole cycles
`define ASR_CYC(ps) (((ps) + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_N_DATA_SETUP `ASR_CYC(`ASR_T_DATA_SETUP_PS)
`define ASR_N_ADDR_SETUP `ASR_CYC(`ASR_T_ADDR_SETUP_PS)
`define ASR_N_LANE_VALID `ASR_CYC(`ASR_T_LANE_VALID_PS)
`define ASR_N_STROBE_DRIVE_ON `ASR_CYC(`ASR_T_STROBE_DRIVE_ON_PS)
`define ASR_N_OE_FLOAT `ASR_CYC(`ASR_T_OE_FLOAT_PS)
`define ASR_N_READ_ACCESS `ASR_CYC(`ASR_T_READ_ACCESS_PS)
`define ASR_N_STROBE_HIGH_DRIVE `ASR_CYC(`ASR_T_STROBE_HIGH_DRIVE_PS)
`endif

/* File: rtl/asr_pkg.sv */
package asr_pkg;
  typedef enum logic [2:0] {
    ASR_IDLE,
    ASR_WR_FLOAT,
    ASR_WR_PULSE,
    ASR_WR_CLOSE,
    ASR_RD_ACCESS,
    ASR_RD_DONE
  } asr_state_t;
  typedef logic [7:0] asr_count_t;
endpackage

/* File: rtl/asr_sync2.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module asr_sync2 #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* File: rtl/asr_ctrl.sv */
`timescale 1ns/1ps
`include "asr_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - write opens when all signals valid; releasing any one ends it.
// - setup and hold counted from the edge that ends the window.
// - write data stable ahead of the window end by data setup time.
// - write data may change at the terminating edge.
// - address valid ahead of the window end by address setup time.
// - address may change at the terminating edge.
// - lane selects low ahead of the window end by lane valid time.
// - with output enable low, strobe low pulse lasts the longer width.
// - strobe may stay low over many addresses; lanes open each write.
// - write strobe stays high through every read.
// - address-driven read keeps select, enable and lane low throughout.
// - in select-driven read, address valid no later than select falls.
// - output enable high some time before strobe falls, bus floats.
// - chip select already high before the retention state is entered.
module asr_ctrl #(
  parameter int ADDR_W = `ASR_ADDR_W,
  parameter int DATA_W = `ASR_DATA_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  input wire logic burst_hold,
  input wire logic retain_req,
  // user answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic retain_ok,
  // memory pins
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic low_lane_select_n,
  output logic high_lane_select_n,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [DATA_W-1:0] mem_dq_i,
  // state
  output asr_pkg::asr_state_t state
);
  import asr_pkg::*;

  localparam asr_count_t N_SETUP = asr_count_t'(`ASR_N_ADDR_SETUP);
  localparam asr_count_t N_PULSE = asr_count_t'(`ASR_N_STROBE_DRIVE_ON);
  localparam asr_count_t N_FLOAT = asr_count_t'(`ASR_N_OE_FLOAT);
  localparam asr_count_t N_READ = asr_count_t'(`ASR_N_READ_ACCESS + 2);
  localparam asr_count_t N_TURN = asr_count_t'(`ASR_N_STROBE_HIGH_DRIVE);
  localparam asr_count_t N_DSET = asr_count_t'(`ASR_N_DATA_SETUP);
  localparam asr_count_t N_LANE = asr_count_t'(`ASR_N_LANE_VALID);
  // the window is held for the widest of address, lane, data and strobe figures
  localparam asr_count_t N_WIN_A = (N_SETUP > N_LANE) ? N_SETUP : N_LANE;
  localparam asr_count_t N_WIN_B = (N_DSET > N_PULSE) ? N_DSET : N_PULSE;
  localparam asr_count_t N_WIN = (N_WIN_A > N_WIN_B) ? N_WIN_A : N_WIN_B;

  asr_state_t state_q;
  asr_state_t state_d;
  asr_count_t cnt_q;
  logic strobe_held_q;
  logic [DATA_W-1:0] rdata_sync;
  logic [1:0] lanes_q;
  logic last_write_q;
  logic burst_keep;

  assign state = state_q;
  // strobe stays low from the closing phase of a burst write until the next one
  assign burst_keep = burst_hold && (strobe_held_q || state_q == ASR_WR_CLOSE || state_d == ASR_WR_CLOSE);

  ////////////////////////////////////////////////////////////////////////////
  // read data passes two flops before use
  asr_sync2 #(
    .WIDTH(DATA_W)
  ) u_rd_sync (
    .clock(clock),
    .rstn(rstn),
    .din(mem_dq_i),
    .dout(rdata_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // accept only in idle; after a write, wait for the memory to release
  assign req_ready = (state_q == ASR_IDLE) && !retain_req
    && !(last_write_q && cnt_q != '0);
  assign retain_ok = (state_q == ASR_IDLE) && chip_select_n && retain_req;

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ASR_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          if (req_write)
            state_d = strobe_held_q ? ASR_WR_PULSE : ASR_WR_FLOAT;
          else
            state_d = ASR_RD_ACCESS;
        end
      end
      ASR_WR_FLOAT:
      begin
        if (cnt_q == '0)
          state_d = ASR_WR_PULSE;
      end
      ASR_WR_PULSE:
      begin
        if (cnt_q == '0)
          state_d = ASR_WR_CLOSE;
      end
      ASR_WR_CLOSE:
        state_d = ASR_IDLE;
      ASR_RD_ACCESS:
      begin
        if (cnt_q == '0)
          state_d = ASR_RD_DONE;
      end
      ASR_RD_DONE:
        state_d = ASR_IDLE;
      default:
        state_d = ASR_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      state_q <= ASR_IDLE;
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase counter; also spaces the bus turnaround after a write
  always_ff @(posedge clock)
  begin
    if (!rstn)
      cnt_q <= '0;
    else if (state_q != state_d)
    begin
      case (state_d)
        ASR_WR_FLOAT: cnt_q <= N_FLOAT - 8'h01;
        ASR_WR_PULSE: cnt_q <= N_WIN - 8'h01;
        ASR_RD_ACCESS: cnt_q <= N_READ - 8'h01;
        ASR_IDLE: cnt_q <= last_write_q ? N_TURN : 8'h00;
        default: cnt_q <= 8'h00;
      endcase
    end
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 8'h01;
  end

  // kind of the most recent access
  always_ff @(posedge clock)
  begin
    if (!rstn)
      last_write_q <= 1'b0;
    else if (req_valid && req_ready)
      last_write_q <= req_write;
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and lanes latch at acceptance, held through the window
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      mem_addr <= '0;
      mem_dq_o <= '0;
      lanes_q <= 2'h0;
    end
    else if (req_valid && req_ready)
    begin
      mem_addr <= req_addr; // valid from the same edge where select falls
      mem_dq_o <= req_wdata; // change only after window
      lanes_q <= (req_lanes == 2'h0) ? 2'h3 : req_lanes;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control pins; strobe held low in burst mode between writes
  always_ff @(posedge clock)
  begin
    if (!rstn)
      strobe_held_q <= 1'b0;
    else if (state_q == ASR_WR_CLOSE)
      strobe_held_q <= burst_hold;
    else if (state_d == ASR_RD_ACCESS || !burst_hold)
      strobe_held_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      low_lane_select_n <= 1'b1;
      high_lane_select_n <= 1'b1;
      mem_dq_oe <= 1'b0;
    end
    else
    begin
      // select low for any access; high deselects the memory
      chip_select_n <= !(state_d != ASR_IDLE || burst_keep);
      // enable stays high on writes so the memory never fights us
      output_enable_n <= !(state_d == ASR_RD_ACCESS || state_d == ASR_RD_DONE);
      // no lift between chained writes: only the lanes open and close them
      write_strobe_n <= !(state_d == ASR_WR_PULSE
        || ((state_d == ASR_WR_CLOSE || state_d == ASR_IDLE) && burst_keep));
      // lane pulses close each write; they alone end a burst write
      low_lane_select_n <= !((state_d == ASR_WR_PULSE || state_d == ASR_RD_ACCESS
        || state_d == ASR_RD_DONE) && lanes_q[0]);
      high_lane_select_n <= !((state_d == ASR_WR_PULSE || state_d == ASR_RD_ACCESS
        || state_d == ASR_RD_DONE) && lanes_q[1]);
      // drive only while the strobe is low and enable high
      mem_dq_oe <= (state_d == ASR_WR_PULSE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data captured after access time plus synchroniser delay
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state_q == ASR_RD_DONE);
      if (state_q == ASR_RD_DONE)
      begin
        // unselected lanes read zero; selected lanes pass the synchronised data
        rsp_rdata[7:0] <= lanes_q[0] ? rdata_sync[7:0] : 8'h00;
        rsp_rdata[DATA_W-1:8] <= lanes_q[1] ? rdata_sync[DATA_W-1:8] : '0;
      end
    end
  end
endmodule

/* File: testbench/asr_sram_model.sv */
`timescale 1ns/1ps
// far-side static memory, behavioural, no timing
module asr_sram_model (
  // control pins
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic low_lane_select_n,
  input wire logic high_lane_select_n,
  // address and data
  input wire logic [16:0] mem_addr,
  input wire logic [15:0] dq,
  output logic [15:0] dq_drv
);
  logic [15:0] mem [0:255];
  logic [15:0] word;
  logic drive;
  logic [15:0] dq_late;
  // writes see the bus a little late, so a closing edge never picks up the next value
  assign #1 dq_late = dq;
  // only low address bits kept, tests stay below 256
  assign word = mem[mem_addr[7:0]];
  // store bytes whole, only on lanes whose select is low
  always @*
  begin
    if (!chip_select_n && !write_strobe_n)
    begin
      if (!low_lane_select_n)
        mem[mem_addr[7:0]][7:0] = dq_late[7:0];
      if (!high_lane_select_n)
        mem[mem_addr[7:0]][15:8] = dq_late[15:8];
    end
  end
  // released lanes show the inverse so a stale value never passes
  assign drive = !chip_select_n && !output_enable_n && write_strobe_n;
  assign dq_drv[7:0] = (drive && !low_lane_select_n) ? word[7:0] : ~word[7:0];
  assign dq_drv[15:8] = (drive && !high_lane_select_n) ? word[15:8] : ~word[15:8];
endmodule

/* File: testbench/asr_ctrl_chk.sv */
`timescale 1ns/1ps
// pin timing watcher
module asr_ctrl_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // user side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic retain_ok,
  // memory pins
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic low_lane_select_n,
  input wire logic high_lane_select_n,
  input wire logic [16:0] mem_addr,
  input wire logic [15:0] mem_dq_o
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic win;
  // write window as the memory sees it
  assign win = !chip_select_n && !write_strobe_n && !(low_lane_select_n && high_lane_select_n);
  sequence wr_end;
    $fell(win);
  endsequence
  sequence rd_take;
    req_valid && req_ready && !req_write;
  endsequence
  win_len_a: assert property (wr_end |-> $past(win, 3))
    else $error("write window short");
  data_setup_a: assert property (wr_end |-> $past(mem_dq_o) == $past(mem_dq_o, 3))
    else $error("data moved before window end");
  addr_setup_a: assert property (wr_end |-> $past(mem_addr) == $past(mem_addr, 3))
    else $error("address moved before window end");
  lane_valid_a: assert property (wr_end |-> $past(low_lane_select_n) == $past(low_lane_select_n, 3))
    else $error("lane select moved before window end");
  strobe_width_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5])
    else $error("strobe pulse short");
  read_strobe_a: assert property (!output_enable_n |-> write_strobe_n)
    else $error("strobe low in read");
  float_first_a: assert property ($fell(write_strobe_n) |-> $past(output_enable_n))
    else $error("enable low before strobe");
  read_len_a: assert property (rd_take |-> ##1 (!chip_select_n && !output_enable_n) [*8] ##1 output_enable_n)
    else $error("read phase length wrong");
  read_addr_a: assert property (!output_enable_n && !$past(output_enable_n) |-> $stable(mem_addr))
    else $error("address moved in read");
  retain_sel_a: assert property (retain_ok |-> chip_select_n && write_strobe_n && low_lane_select_n
    && high_lane_select_n)
    else $error("retention with select low");
endmodule
bind asr_ctrl asr_ctrl_chk asr_ctrl_chk_inst (.clock, .rstn, .req_valid, .req_ready, .req_write, .retain_ok,
  .chip_select_n, .output_enable_n, .write_strobe_n, .low_lane_select_n, .high_lane_select_n, .mem_addr,
  .mem_dq_o);

/* File: testbench/asr_ctrl_tb.sv */
`timescale 1ns/1ps
module asr_ctrl_tb;
  import asr_pkg::*;
  logic clock, rstn, req_valid, req_write, burst_hold, retain_req;
  logic req_ready, rsp_valid, retain_ok, chip_select_n, output_enable_n, write_strobe_n;
  logic low_lane_select_n, high_lane_select_n, mem_dq_oe;
  logic [16:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rsp_rdata, mem_dq_o, mem_dq_i, sram_dq;
  logic [1:0] req_lanes;
  asr_state_t state;
  int mismatches = 0;
  int check_count = 0;
  int we_rises = 0;
  asr_ctrl asr_ctrl_inst (.clock, .rstn, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
    .req_lanes, .burst_hold, .retain_req, .rsp_valid, .rsp_rdata, .retain_ok, .chip_select_n,
    .output_enable_n, .write_strobe_n, .low_lane_select_n, .high_lane_select_n, .mem_addr,
    .mem_dq_o, .mem_dq_oe, .mem_dq_i, .state);
  // the controller wins the shared bus while it drives
  assign mem_dq_i = mem_dq_oe ? mem_dq_o : sram_dq;
  asr_sram_model asr_sram_model_inst (.chip_select_n, .output_enable_n, .write_strobe_n,
    .low_lane_select_n, .high_lane_select_n, .mem_addr, .dq(mem_dq_i), .dq_drv(sram_dq));
  // clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // strobe must not lift between chained writes
  always @(posedge clock)
    if (burst_hold && $rose(write_strobe_n))
      we_rises <= we_rises + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  // hold the request until taken, bounded
  task automatic issue(input logic w, input logic [16:0] a, input logic [15:0] d, input logic [1:0] l);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= l;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (req_ready !== 1'b1 && n < 60);
    req_valid <= 1'b0;
    @(posedge clock);
    if (n >= 60)
    begin
      mismatches++;
      give_verdict;
    end
  endtask
  task automatic rd(input logic [16:0] a, input logic [1:0] l, input logic [15:0] e);
    int n;
    n = 0;
    issue(1'b0, a, 16'h0000, l);
    while (rsp_valid !== 1'b1 && n < 30)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 30)
    begin
      mismatches++;
      give_verdict;
    end
    chk("read data", e, rsp_rdata);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk1("select", 1'b1, chip_select_n);
    chk1("strobe", 1'b1, write_strobe_n);
    chk1("drive", 1'b0, mem_dq_oe);
    chk1("enable", 1'b1, output_enable_n);
    chk1("low lane", 1'b1, low_lane_select_n);
    chk1("high lane", 1'b1, high_lane_select_n);
    chk("state", {13'h0000, ASR_IDLE}, {13'h0000, state});
  endtask
  // reset in the middle of a read drops it and leaves the port usable
  task automatic t_midreset;
    issue(1'b0, 17'h00010, 16'h0000, 2'h3);
    repeat (2) @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset;
    chk1("answer", 1'b0, rsp_valid);
    rd(17'h00010, 2'h3, 16'hA534);
  endtask
  // full word, then one lane over it
  task automatic t_lanes;
    issue(1'b1, 17'h00010, 16'hA55A, 2'h3);
    rd(17'h00010, 2'h3, 16'hA55A);
    issue(1'b1, 17'h00010, 16'h1234, 2'h1);
    rd(17'h00010, 2'h3, 16'hA534);
    rd(17'h00010, 2'h2, 16'hA500);
  endtask
  task automatic t_burst;
    burst_hold <= 1'b1;
    issue(1'b1, 17'h00020, 16'h1111, 2'h3);
    issue(1'b1, 17'h00021, 16'h2222, 2'h3);
    burst_hold <= 1'b0;
    rd(17'h00020, 2'h3, 16'h1111);
    rd(17'h00021, 2'h3, 16'h2222);
    chk("strobe lifts", 16'h0000, we_rises[15:0]);
  endtask
  task automatic t_retain;
    retain_req <= 1'b1;
    req_valid <= 1'b1;
    repeat (4) @(posedge clock);
    chk1("ready", 1'b0, req_ready);
    chk1("retain", 1'b1, retain_ok);
    chk1("select", 1'b1, chip_select_n);
    retain_req <= 1'b0;
    req_valid <= 1'b0;
    @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    burst_hold = 1'b0;
    retain_req = 1'b0;
    req_addr = 17'h00000;
    req_wdata = 16'h0000;
    req_lanes = 2'h3;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset;
    t_lanes;
    t_burst;
    t_retain;
    t_midreset;
    give_verdict;
  end
endmodule
